// File: flow_module_command_decoder.sv
// command decoder of the flow module: one code in, its action pulses or levels out
// assumes: codes arrive as one-cycle strobes on core_clk_in; engines outside act on pulses
//
// What this block does
// RL1 - act on each code directly, no translation
// RL2 - codes 1-4 pulse batch start/hold/continue/stop
// RL3 - code 5 clears batch repeat tally
// RL4 - code 6 zeroes first sum, runs
// RL5 - code 7 holds first sum, keeps value
// RL6 - code 8 resumes first sum
// RL7 - code 9 loads first sum preset, runs
// RL8 - code 10 zeroes second sum, runs
// RL9 - code 11 holds second sum
// RL10 - code 12 resumes second sum
// RL11 - code 13 loads second sum preset, runs
// RL12 - code 14 zeroes both sums, runs both
// RL13 - code 15 holds both sums together
// RL14 - code 16 resumes both sums
// RL15 - code 17 loads both presets, runs both
// RL16 - code 18 starts automatic zero adjustment
// RL17 - code 19 clears the other source's change flag
// RL18 - code 20 restores defaults, flag after store
// RL19 - codes 21-24 freeze/unfreeze, force/unforce outputs
// RL20 - code 25 copies zero preset into active
// RL21 - code 251 re-reads all control area fields
// RL22 - code 252 takes input variable fields
// RL23 - code 253 takes digital output field
// RL24 - codes 254/255 take output selector addresses
// RL25 - 8-bit code, 0 invalid, 26-250 ignored
`timescale 1ns/1ps
`include "flow_cmd_consts.svh"
module flow_module_command_decoder (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // command strobe
  input wire logic cmd_valid_in,
  input wire logic [`CMD_W-1:0] cmd_code_in,
  input wire logic cmd_from_serial_in,
  // setting change reports from the parameter store
  input wire logic backplane_change_in,
  input wire logic serial_change_in,
  // default restore handshake with the sensor memory writer
  input wire logic defaults_stored_in,
  // batch controller pulses
  output logic batch_start_out,
  output logic batch_hold_out,
  output logic batch_continue_out,
  output logic batch_stop_out,
  output logic tally_clear_out,
  // totalizer controls
  output logic sum_a_zero_out,
  output logic sum_a_load_out,
  output logic sum_a_run_out,
  output logic sum_b_zero_out,
  output logic sum_b_load_out,
  output logic sum_b_run_out,
  // measurement and settings
  output logic auto_null_cal_out,
  output logic defaults_restore_out,
  output logic defaults_restored_flag_out,
  output logic settings_altered_by_backplane_flag_out,
  output logic settings_altered_by_serial_flag_out,
  output logic null_copy_out,
  // output stage levels
  output logic freeze_out,
  output logic force_out,
  // control area take-over pulses
  output logic take_in_addr_out,
  output logic take_in_value_out,
  output logic take_dout_out,
  output logic take_outsel_a_out,
  output logic take_outsel_b_out,
  // diagnostics
  output logic invalid_code_out
);

  flow_cmd_pkg::defaults_state_t def_state;
  logic [`CMD_W-1:0] code;
  logic hit;

  // code is used straight from the port, no staging register
  assign code = cmd_code_in; // RL1
  assign hit = cmd_valid_in;

  function automatic logic is_code(input logic [`CMD_W-1:0] c, input logic [`CMD_W-1:0] k);
    is_code = (c == k);
  endfunction

  // batch requests and tally clear as one-cycle pulses
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      batch_start_out <= 1'b0;
      batch_hold_out <= 1'b0;
      batch_continue_out <= 1'b0;
      batch_stop_out <= 1'b0;
      tally_clear_out <= 1'b0;
    end else begin
      batch_start_out <= hit && is_code(code, `CMD_BATCH_GO); // RL2
      batch_hold_out <= hit && is_code(code, `CMD_BATCH_PAUSE); // RL2
      batch_continue_out <= hit && is_code(code, `CMD_BATCH_RESUME); // RL2
      batch_stop_out <= hit && is_code(code, `CMD_BATCH_END); // RL2
      tally_clear_out <= hit && is_code(code, `CMD_TALLY_CLEAR); // RL3
    end
  end

  // zero and load pulses; the combined codes drive both sums in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sum_a_zero_out <= 1'b0;
      sum_a_load_out <= 1'b0;
      sum_b_zero_out <= 1'b0;
      sum_b_load_out <= 1'b0;
    end else begin
      sum_a_zero_out <= hit && (is_code(code, `CMD_SUM_A_ZERO) // RL4
        || is_code(code, `CMD_SUM_AB_ZERO)); // RL12
      sum_a_load_out <= hit && (is_code(code, `CMD_SUM_A_LOAD) // RL7
        || is_code(code, `CMD_SUM_AB_LOAD)); // RL15
      sum_b_zero_out <= hit && (is_code(code, `CMD_SUM_B_ZERO) // RL8
        || is_code(code, `CMD_SUM_AB_ZERO)); // RL12
      sum_b_load_out <= hit && (is_code(code, `CMD_SUM_B_LOAD) // RL11
        || is_code(code, `CMD_SUM_AB_LOAD)); // RL15
    end
  end

  // first sum run level: counting from reset, dropped only by a hold
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sum_a_run_out <= 1'b1;
    end else if (hit) begin
      unique case (code)
        `CMD_SUM_A_HOLD, `CMD_SUM_AB_HOLD: sum_a_run_out <= 1'b0; // RL5 RL13
        `CMD_SUM_A_RUN, `CMD_SUM_AB_RUN: sum_a_run_out <= 1'b1; // RL6 RL14
        `CMD_SUM_A_ZERO, `CMD_SUM_A_LOAD: sum_a_run_out <= 1'b1; // RL4 RL7
        `CMD_SUM_AB_ZERO, `CMD_SUM_AB_LOAD: sum_a_run_out <= 1'b1; // RL12 RL15
        default: sum_a_run_out <= sum_a_run_out;
      endcase
    end
  end

  // second sum run level
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sum_b_run_out <= 1'b1;
    end else if (hit) begin
      unique case (code)
        `CMD_SUM_B_HOLD, `CMD_SUM_AB_HOLD: sum_b_run_out <= 1'b0; // RL9 RL13
        `CMD_SUM_B_RUN, `CMD_SUM_AB_RUN: sum_b_run_out <= 1'b1; // RL10 RL14
        `CMD_SUM_B_ZERO, `CMD_SUM_B_LOAD: sum_b_run_out <= 1'b1; // RL8 RL11
        `CMD_SUM_AB_ZERO, `CMD_SUM_AB_LOAD: sum_b_run_out <= 1'b1; // RL12 RL15
        default: sum_b_run_out <= sum_b_run_out;
      endcase
    end
  end

  // single pulses to the measurement side and to diagnostics
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      auto_null_cal_out <= 1'b0;
      null_copy_out <= 1'b0;
      invalid_code_out <= 1'b0;
    end else begin
      auto_null_cal_out <= hit && is_code(code, `CMD_AUTO_NULL); // RL16
      null_copy_out <= hit && is_code(code, `CMD_NULL_COPY); // RL20
      // reserved codes fall through every decode and touch nothing
      invalid_code_out <= hit && is_code(code, `CMD_INVALID); // RL25
    end
  end

  // change flags: a new change report wins over an acknowledge in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      settings_altered_by_backplane_flag_out <= 1'b0;
      settings_altered_by_serial_flag_out <= 1'b0;
    end else begin
      if (backplane_change_in) begin
        settings_altered_by_backplane_flag_out <= 1'b1;
      end else if (hit && is_code(code, `CMD_SETTING_ACK) && cmd_from_serial_in) begin
        settings_altered_by_backplane_flag_out <= 1'b0; // RL17
      end
      if (serial_change_in) begin
        settings_altered_by_serial_flag_out <= 1'b1;
      end else if (hit && is_code(code, `CMD_SETTING_ACK) && !cmd_from_serial_in) begin
        settings_altered_by_serial_flag_out <= 1'b0; // RL17
      end
    end
  end

  // default restore: flag rises only once the memory writer reports completion
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      def_state <= flow_cmd_pkg::DEF_IDLE;
      defaults_restore_out <= 1'b0;
      defaults_restored_flag_out <= 1'b0;
    end else begin
      defaults_restore_out <= 1'b0;
      unique case (def_state)
        flow_cmd_pkg::DEF_IDLE: begin
          if (hit && is_code(code, `CMD_DEFAULTS)) begin
            defaults_restore_out <= 1'b1; // RL18
            defaults_restored_flag_out <= 1'b0;
            def_state <= flow_cmd_pkg::DEF_WAIT;
          end
        end
        flow_cmd_pkg::DEF_WAIT: begin
          if (defaults_stored_in) begin
            defaults_restored_flag_out <= 1'b1; // RL18
            def_state <= flow_cmd_pkg::DEF_IDLE;
          end
        end
        default: def_state <= flow_cmd_pkg::DEF_IDLE;
      endcase
    end
  end

  // output stage levels, freeze and force kept independent
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      freeze_out <= 1'b0;
      force_out <= 1'b0;
    end else if (hit) begin
      if (is_code(code, `CMD_FREEZE_ON)) freeze_out <= 1'b1; // RL19
      if (is_code(code, `CMD_FREEZE_OFF)) freeze_out <= 1'b0; // RL19
      if (is_code(code, `CMD_FORCE_ON)) force_out <= 1'b1; // RL19
      if (is_code(code, `CMD_FORCE_OFF)) force_out <= 1'b0; // RL19
    end
  end

  // control area take-over pulses; code 251 fires all of them
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      take_in_addr_out <= 1'b0;
      take_in_value_out <= 1'b0;
      take_dout_out <= 1'b0;
      take_outsel_a_out <= 1'b0;
      take_outsel_b_out <= 1'b0;
    end else begin
      take_in_addr_out <= hit && (is_code(code, `CMD_AREA_ALL) // RL21
        || is_code(code, `CMD_AREA_INVAR)); // RL22
      take_in_value_out <= hit && (is_code(code, `CMD_AREA_ALL) // RL21
        || is_code(code, `CMD_AREA_INVAR)); // RL22
      take_dout_out <= hit && (is_code(code, `CMD_AREA_ALL) // RL21
        || is_code(code, `CMD_AREA_DOUT)); // RL23
      take_outsel_a_out <= hit && (is_code(code, `CMD_AREA_ALL) // RL21
        || is_code(code, `CMD_AREA_OUTSEL_A)); // RL24
      take_outsel_b_out <= hit && (is_code(code, `CMD_AREA_ALL) // RL21
        || is_code(code, `CMD_AREA_OUTSEL_B)); // RL24
    end
  end

  // checks
  a_batch_start_pulse: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL2
    (cmd_valid_in && cmd_code_in == `CMD_BATCH_GO) |=> batch_start_out && !batch_stop_out)
    else $error("batch start not pulsed");
  a_tally_clear: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL3
    tally_clear_out |-> $past(cmd_valid_in) && $past(cmd_code_in) == `CMD_TALLY_CLEAR)
    else $error("tally clear without code 5");
  a_sum_a_hold: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL5
    (cmd_valid_in && cmd_code_in == `CMD_SUM_A_HOLD) |=> !sum_a_run_out
     && sum_b_run_out == $past(sum_b_run_out))
    else $error("first sum hold wrong");
  a_sum_a_resume: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL6
    (cmd_valid_in && cmd_code_in == `CMD_SUM_A_RUN) |=> sum_a_run_out)
    else $error("first sum not resumed");
  a_both_zero: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL12
    (cmd_valid_in && cmd_code_in == `CMD_SUM_AB_ZERO) |=> sum_a_zero_out && sum_b_zero_out
     && sum_a_run_out && sum_b_run_out)
    else $error("both sums not zeroed");
  a_both_hold: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL13
    (cmd_valid_in && cmd_code_in == `CMD_SUM_AB_HOLD) |=> !sum_a_run_out && !sum_b_run_out)
    else $error("both sums not held");
  a_ack_serial: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL17
    (cmd_valid_in && cmd_code_in == `CMD_SETTING_ACK && cmd_from_serial_in && !backplane_change_in
     && !serial_change_in) |=> !settings_altered_by_backplane_flag_out
     && settings_altered_by_serial_flag_out == $past(settings_altered_by_serial_flag_out))
    else $error("ack cleared wrong flag");
  a_defaults_flag: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL18
    $rose(defaults_restored_flag_out) |-> $past(defaults_stored_in))
    else $error("defaults flag before store");
  a_freeze_on: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL19
    (cmd_valid_in && cmd_code_in == `CMD_FREEZE_ON) |=> freeze_out
     && force_out == $past(force_out))
    else $error("freeze not set");
  a_area_all: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL21
    (cmd_valid_in && cmd_code_in == `CMD_AREA_ALL) |=> take_in_addr_out && take_dout_out
     && take_outsel_a_out && take_outsel_b_out)
    else $error("control area not fully taken");
  a_reserved_quiet: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL25
    (cmd_valid_in && cmd_code_in > `CMD_NULL_COPY && cmd_code_in <= `CMD_RSVD_LAST)
     |=> !batch_start_out && !sum_a_zero_out && !take_dout_out && !invalid_code_out
     && $stable(freeze_out) && $stable(sum_a_run_out))
    else $error("reserved code acted");
  // remaining checks; all but the no-strobe and change-report ones start from a code the bench sweeps
  a_no_strobe_quiet: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL1
    !cmd_valid_in |=> !batch_start_out && !tally_clear_out && !sum_a_zero_out
     && !take_dout_out && !null_copy_out && !invalid_code_out)
    else $error("pulse without a strobe");
  a_sum_a_zero: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL4
    (cmd_valid_in && cmd_code_in == `CMD_SUM_A_ZERO)
     |=> sum_a_zero_out && !sum_b_zero_out && sum_a_run_out)
    else $error("first sum not zeroed");
  a_sum_a_load: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL7
    (cmd_valid_in && cmd_code_in == `CMD_SUM_A_LOAD)
     |=> sum_a_load_out && !sum_b_load_out && sum_a_run_out)
    else $error("first sum not loaded");
  a_sum_b_zero: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL8
    (cmd_valid_in && cmd_code_in == `CMD_SUM_B_ZERO)
     |=> sum_b_zero_out && !sum_a_zero_out && sum_b_run_out)
    else $error("second sum not zeroed");
  a_sum_b_hold: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL9
    (cmd_valid_in && cmd_code_in == `CMD_SUM_B_HOLD)
     |=> !sum_b_run_out && sum_a_run_out == $past(sum_a_run_out))
    else $error("second sum hold wrong");
  a_sum_b_resume: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL10
    (cmd_valid_in && cmd_code_in == `CMD_SUM_B_RUN) |=> sum_b_run_out)
    else $error("second sum not resumed");
  a_sum_b_load: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL11
    (cmd_valid_in && cmd_code_in == `CMD_SUM_B_LOAD)
     |=> sum_b_load_out && !sum_a_load_out && sum_b_run_out)
    else $error("second sum not loaded");
  a_both_resume: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL14
    (cmd_valid_in && cmd_code_in == `CMD_SUM_AB_RUN) |=> sum_a_run_out && sum_b_run_out)
    else $error("both sums not resumed");
  a_both_load: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL15
    (cmd_valid_in && cmd_code_in == `CMD_SUM_AB_LOAD)
     |=> sum_a_load_out && sum_b_load_out && sum_a_run_out && sum_b_run_out)
    else $error("both sums not loaded");
  a_auto_null_pulse: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL16
    (cmd_valid_in && cmd_code_in == `CMD_AUTO_NULL) |=> auto_null_cal_out && !null_copy_out)
    else $error("zero adjustment not started");
  a_null_copy: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL20
    (cmd_valid_in && cmd_code_in == `CMD_NULL_COPY) |=> null_copy_out && !auto_null_cal_out)
    else $error("zero offset not copied");
  a_change_set_wins: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL17
    backplane_change_in |=> settings_altered_by_backplane_flag_out)
    else $error("backplane change flag not set");
  a_restore_refused: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL18
    (def_state == flow_cmd_pkg::DEF_WAIT && cmd_valid_in && cmd_code_in == `CMD_DEFAULTS)
     |=> !defaults_restore_out)
    else $error("restore repeated while storing");
  a_force_on: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL19
    (cmd_valid_in && cmd_code_in == `CMD_FORCE_ON) |=> force_out
     && freeze_out == $past(freeze_out))
    else $error("force not set");
  a_in_var_take: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL22
    (cmd_valid_in && cmd_code_in == `CMD_AREA_INVAR)
     |=> take_in_addr_out && take_in_value_out && !take_dout_out)
    else $error("input variable fields not taken");
  a_dout_take: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL23
    (cmd_valid_in && cmd_code_in == `CMD_AREA_DOUT) |=> take_dout_out && !take_in_addr_out)
    else $error("digital output field not taken");
  a_outsel_a_take: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL24
    (cmd_valid_in && cmd_code_in == `CMD_AREA_OUTSEL_A)
     |=> take_outsel_a_out && !take_outsel_b_out)
    else $error("first selector not taken");
  a_outsel_b_take: assert property (@(posedge core_clk_in) disable iff (rst_in) // RL24
    (cmd_valid_in && cmd_code_in == `CMD_AREA_OUTSEL_B)
     |=> take_outsel_b_out && !take_outsel_a_out)
    else $error("second selector not taken");

endmodule

// File: flow_cmd_consts.svh
// command codes and widths for the flow module command decoder
// assumes: included by bare name, no other header defines these names
`ifndef FLOW_CMD_CONSTS_SVH
`define FLOW_CMD_CONSTS_SVH
`define CMD_W 8
`define CMD_INVALID 8'h00
`define CMD_BATCH_GO 8'h01
`define CMD_BATCH_PAUSE 8'h02
`define CMD_BATCH_RESUME 8'h03
`define CMD_BATCH_END 8'h04
`define CMD_TALLY_CLEAR 8'h05
`define CMD_SUM_A_ZERO 8'h06
`define CMD_SUM_A_HOLD 8'h07
`define CMD_SUM_A_RUN 8'h08
`define CMD_SUM_A_LOAD 8'h09
`define CMD_SUM_B_ZERO 8'h0a
`define CMD_SUM_B_HOLD 8'h0b
`define CMD_SUM_B_RUN 8'h0c
`define CMD_SUM_B_LOAD 8'h0d
`define CMD_SUM_AB_ZERO 8'h0e
`define CMD_SUM_AB_HOLD 8'h0f
`define CMD_SUM_AB_RUN 8'h10
`define CMD_SUM_AB_LOAD 8'h11
`define CMD_AUTO_NULL 8'h12
`define CMD_SETTING_ACK 8'h13
`define CMD_DEFAULTS 8'h14
`define CMD_FREEZE_ON 8'h15
`define CMD_FREEZE_OFF 8'h16
`define CMD_FORCE_ON 8'h17
`define CMD_FORCE_OFF 8'h18
`define CMD_NULL_COPY 8'h19
`define CMD_RSVD_LAST 8'hfa
`define CMD_AREA_ALL 8'hfb
`define CMD_AREA_INVAR 8'hfc
`define CMD_AREA_DOUT 8'hfd
`define CMD_AREA_OUTSEL_A 8'hfe
`define CMD_AREA_OUTSEL_B 8'hff
`endif

// File: flow_cmd_pkg.sv
// types shared by the flow module command decoder
// assumes: compiled before the decoder module
package flow_cmd_pkg;
  typedef enum logic [1:0] {
    DEF_IDLE = 2'b00,
    DEF_WAIT = 2'b01
  } defaults_state_t;
  typedef enum logic {
    SRC_BACKPLANE = 1'b0,
    SRC_SERIAL = 1'b1
  } cmd_source_t;
endpackage

// File: flow_mem_writer_model.sv
// behavioural model of the sensor memory writer beside the command decoder
// assumes: one clock, sync active-high reset, restore request is a one-cycle pulse
`timescale 1ns/1ps
module flow_mem_writer_model (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // request and write time in cycles
  input wire logic restore_in,
  input wire logic [7:0] delay_in,
  // completion pulse
  output logic stored_out
);
  logic busy;
  logic [7:0] cnt;
  // store all defaults, then report once; a new request during a write is ignored
  always_ff @(posedge core_clk_in) begin
    stored_out <= 1'b0;
    if (rst_in) begin
      busy <= 1'b0;
      cnt <= 8'h00;
    end else if (busy) begin
      if (cnt == 8'h00) begin
        busy <= 1'b0;
        stored_out <= 1'b1;
      end else begin
        cnt <= cnt - 8'h01;
      end
    end else if (restore_in) begin
      busy <= 1'b1;
      cnt <= delay_in;
    end
  end
endmodule

// File: tb_flow_module_command_decoder.sv
// self-checking bench for the command decoder: every code, back to back, defaults, acks
// assumes: decoder answers one cycle after the strobe edge, memory writer model beside it
`timescale 1ns/1ps
module tb_flow_module_command_decoder;
  logic core_clk_in, rst_in, cmd_valid_in, cmd_from_serial_in;
  logic backplane_change_in, serial_change_in, defaults_stored_in;
  logic [7:0] cmd_code_in, wr_delay;
  logic [17:0] p;
  logic [3:0] lv;
  logic [2:0] fl;
  logic ra, rb, fz, fc;
  int n_mismatch, checks_done, i;

  flow_module_command_decoder flow_module_command_decoder_i (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
    .cmd_code_in(cmd_code_in), .cmd_from_serial_in(cmd_from_serial_in),
    .backplane_change_in(backplane_change_in), .serial_change_in(serial_change_in),
    .defaults_stored_in(defaults_stored_in), .batch_start_out(p[17]),
    .batch_hold_out(p[16]), .batch_continue_out(p[15]), .batch_stop_out(p[14]),
    .tally_clear_out(p[13]), .sum_a_zero_out(p[12]), .sum_a_load_out(p[11]),
    .sum_a_run_out(lv[3]), .sum_b_zero_out(p[10]), .sum_b_load_out(p[9]),
    .sum_b_run_out(lv[2]), .auto_null_cal_out(p[8]), .defaults_restore_out(p[7]),
    .defaults_restored_flag_out(fl[2]), .settings_altered_by_backplane_flag_out(fl[1]),
    .settings_altered_by_serial_flag_out(fl[0]), .null_copy_out(p[6]),
    .freeze_out(lv[1]), .force_out(lv[0]), .take_in_addr_out(p[5]),
    .take_in_value_out(p[4]), .take_dout_out(p[3]), .take_outsel_a_out(p[2]),
    .take_outsel_b_out(p[1]), .invalid_code_out(p[0]));

  flow_mem_writer_model flow_mem_writer_model_i (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .restore_in(p[7]), .delay_in(wr_delay), .stored_out(defaults_stored_in));

  // 25 MHz clock
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // expected pulse outputs per code; level-only, flag-only and reserved codes give nothing
  function automatic logic [17:0] pexp(input logic [7:0] c);
    case (c)
      8'h00: pexp = 18'h00001;
      8'h01: pexp = 18'h20000;
      8'h02: pexp = 18'h10000;
      8'h03: pexp = 18'h08000;
      8'h04: pexp = 18'h04000;
      8'h05: pexp = 18'h02000;
      8'h06: pexp = 18'h01000;
      8'h09: pexp = 18'h00800;
      8'h0a: pexp = 18'h00400;
      8'h0d: pexp = 18'h00200;
      8'h0e: pexp = 18'h01400;
      8'h11: pexp = 18'h00a00;
      8'h12: pexp = 18'h00100;
      8'h14: pexp = 18'h00080;
      8'h19: pexp = 18'h00040;
      8'hfb: pexp = 18'h0003e;
      8'hfc: pexp = 18'h00030;
      8'hfd: pexp = 18'h00008;
      8'hfe: pexp = 18'h00004;
      8'hff: pexp = 18'h00002;
      default: pexp = 18'h00000;
    endcase
  endfunction

  // one strobe, then the answer cycle and the cycle after it
  task automatic issue(input logic [7:0] c, input logic s, input logic [17:0] e);
    @(posedge core_clk_in);
    cmd_valid_in <= 1'b1;
    cmd_code_in <= c;
    cmd_from_serial_in <= s;
    @(posedge core_clk_in);
    cmd_valid_in <= 1'b0;
    case (c)
      8'h06, 8'h08, 8'h09: ra = 1'b1;
      8'h07: ra = 1'b0;
      8'h0a, 8'h0c, 8'h0d: rb = 1'b1;
      8'h0b: rb = 1'b0;
      8'h0e, 8'h10, 8'h11: {ra, rb} = 2'h3;
      8'h0f: {ra, rb} = 2'h0;
      8'h15: fz = 1'b1;
      8'h16: fz = 1'b0;
      8'h17: fc = 1'b1;
      8'h18: fc = 1'b0;
      default: ;
    endcase
    #1;
    chk("pulses", e, p);
    chk("levels", {14'h0, ra, rb, fz, fc}, {14'h0, lv});
    @(posedge core_clk_in);
    #1;
    chk("pulse end", 18'h0, p);
  endtask

  // every code of a range in turn, from the backplane side
  task automatic sweep(input int lo, input int hi);
    for (int k = lo; k <= hi; k++) issue(k[7:0], 1'b0, pexp(k[7:0]));
  endtask

  task automatic report(input logic b, input logic s);
    @(posedge core_clk_in);
    backplane_change_in <= b;
    serial_change_in <= s;
    @(posedge core_clk_in);
    backplane_change_in <= 1'b0;
    serial_change_in <= 1'b0;
    #1;
  endtask

  // reset held five cycles; level model follows the reset values
  task automatic do_reset;
    rst_in <= 1'b1;
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b0;
    {ra, rb, fz, fc} = 4'hc;
    #1;
    chk("reset pulses", 18'h0, p);
    chk("reset levels", 18'h0000c, {14'h0, lv});
    chk("reset flags", 18'h0, {15'h0, fl});
  endtask

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // watchdog: the whole sequence needs about 830 cycles
  initial begin
    repeat (5000) @(posedge core_clk_in);
    n_mismatch++;
    wrap_up;
  end

  initial begin
    {cmd_valid_in, cmd_from_serial_in, backplane_change_in, serial_change_in} <= 4'h0;
    cmd_code_in <= 8'h00;
    wr_delay <= 8'h02;
    do_reset;
    sweep(0, 5);
    sweep(6, 10);
    sweep(11, 17);
    sweep(18, 25);
    sweep(26, 250);
    sweep(251, 255);
    // two zero codes with no gap between strobes
    @(posedge core_clk_in);
    cmd_valid_in <= 1'b1;
    cmd_code_in <= 8'h06;
    @(posedge core_clk_in);
    cmd_code_in <= 8'h0a;
    #1;
    chk("zero a", 18'h01000, p);
    @(posedge core_clk_in);
    cmd_valid_in <= 1'b0;
    #1;
    chk("zero b", 18'h00400, p);
    // slow writer: flag only after the store, repeat request refused meanwhile
    wr_delay = 8'h14;
    issue(8'h14, 1'b0, 18'h00080);
    chk("restored early", 18'h0, {17'h0, fl[2]});
    issue(8'h14, 1'b0, 18'h0);
    for (i = 0; i < 60 && fl[2] !== 1'b1; i++) begin
      @(posedge core_clk_in);
      #1;
    end
    chk("restored", 18'h1, {17'h0, fl[2]});
    chk("restore wait", 18'h1, {17'h0, i > 10});
    report(1'b1, 1'b1);
    chk("change flags", 18'h7, {15'h0, fl});
    issue(8'h13, 1'b1, 18'h0);
    chk("ack serial", 18'h5, {15'h0, fl});
    issue(8'h13, 1'b0, 18'h0);
    chk("ack backplane", 18'h4, {15'h0, fl});
    issue(8'h14, 1'b0, 18'h00080);
    chk("restore clears", 18'h0, {15'h0, fl});
    // reset in mid-run with freeze, force and the backplane change flag set
    issue(8'h15, 1'b0, 18'h0);
    issue(8'h17, 1'b1, 18'h0);
    report(1'b1, 1'b0);
    // reset is raised on a clock edge; a command must work right after release
    @(posedge core_clk_in);
    do_reset;
    issue(8'h07, 1'b0, 18'h0);
    wrap_up;
  end
endmodule
